// ===== verif/drc_serial_master.sv
/*
 * serial master model that sends frames to the diagnostic readout block.
 * assumes a free-running i_clk; every pin changes just after its rising edge.
 */
`timescale 1ns/1ns
module drc_serial_master (
   input wire logic i_clk,
   input wire logic i_miso,
   input wire logic i_miso_oe,
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_mosi
);
   ////////////////////////////////////////////////////////////////////////////
   // idle bus: deselected, serial clock parked low
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one frame, msb first; half sets the speed of each serial clock phase
   // the reply is sampled late in each low phase; undriven bits come back as z
   task automatic xfer(input logic [15:0] tx, input int nbits, input int half,
      output logic [15:0] rx);
      rx = 16'hzzzz;
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      o_mosi <= tx[15];
      for (int i = 0; i < nbits; i++) begin
         repeat (half) @(posedge i_clk);
         @(negedge i_clk);
         rx[15 - i] = i_miso_oe ? i_miso : 1'bz;
         @(posedge i_clk);
         o_sclk <= 1'b1;
         repeat (half) @(posedge i_clk);
         o_sclk <= 1'b0;
         if (i < 15) begin
            o_mosi <= tx[14 - i];
         end
      end
      repeat (half) @(posedge i_clk);
      o_cs_n <= 1'b1;
      // released data line must not keep its last level
      o_mosi <= ~o_mosi;
      repeat (2) @(posedge i_clk);
   endtask : xfer
endmodule : drc_serial_master

// ===== verif/tb.sv
/*
 * self-checking bench for the diagnostic readout block.
 * assumes the serial master model and the block are compiled first.
 */
`timescale 1ns/1ns
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic en_a = 1'b0;
   logic en_b = 1'b0;
   logic [9:0] flt = 10'h000;
   logic cs_n, sclk, mosi, miso, miso_oe;
   int n_mismatch = 0;
   int total_checks = 0;
   // fault input masks: ch1 vs/gnd, ch2 vs/gnd, shorted, open, uv, oc, limit, shutdown
   localparam logic [9:0] C1V = 10'h200, C1G = 10'h100, C2V = 10'h080, C2G = 10'h040;
   localparam logic [9:0] SHL = 10'h020, OPN = 10'h010, UV = 10'h008;
   localparam logic [9:0] OC = 10'h004, LR = 10'h002, SD = 10'h001;
   localparam logic [15:0] RD = 16'h0900;
   localparam logic [15:0] WR = 16'h8000;

   ////////////////////////////////////////////////////////////////////////////
   // clock, block and master
   always #2 clk = ~clk;

   drc_diag_readout dut (
      .i_clk(clk),
      .i_rst_n(rst_n),
      .i_cs_n(cs_n),
      .i_sclk(sclk),
      .i_mosi(mosi),
      .o_miso(miso),
      .o_miso_oe(miso_oe),
      .i_output_enable_cfg_a(en_a),
      .i_output_enable_cfg_b(en_b),
      .i_ch1_short_vs(flt[9]),
      .i_ch1_short_gnd(flt[8]),
      .i_ch2_short_vs(flt[7]),
      .i_ch2_short_gnd(flt[6]),
      .i_shorted_load(flt[5]),
      .i_open_load(flt[4]),
      .i_supply_undervoltage(flt[3]),
      .i_low_side_overcurrent(flt[2]),
      .i_limit_reduction_temp(flt[1]),
      .i_shutdown_temp(flt[0])
   );

   drc_serial_master u_master (
      .i_clk(clk),
      .i_miso(miso),
      .i_miso_oe(miso_oe),
      .o_cs_n(cs_n),
      .o_sclk(sclk),
      .o_mosi(mosi)
   );

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: response %b expected %b", $time, seen, exp);
      end
   endtask : check

   // expected reply: two undriven bits, pattern, error, enable, flags, load code
   function automatic logic [15:0] resp(input logic fe, input logic en,
      input logic [2:0] flg, input logic [3:0] dg);
      return {2'hz, drc_pkg::VERIFY_PATTERN, fe, en, flg, dg};
   endfunction : resp

   task automatic frame(input logic [15:0] cmd, input int nbits, input int half,
      input logic [15:0] exp);
      logic [15:0] rx;
      u_master.xfer(cmd, nbits, half, rx);
      if (nbits == 16) begin
         check(rx, exp);
      end
   endtask : frame

   // short fault event, then released so only a latch can remember it
   task automatic pulse(input logic [9:0] m);
      flt <= m;
      repeat (3) @(posedge clk);
      flt <= 10'h000;
      repeat (2) @(posedge clk);
   endtask : pulse

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      frame(RD, 16, 4, resp(1'b0, 1'b0, 3'h7, 4'h0));
      frame(RD, 16, 4, resp(1'b0, 1'b0, 3'h7, 4'hf));
      en_a <= 1'b1;
      frame(RD, 16, 4, resp(1'b0, 1'b1, 3'h7, 4'hf));
      en_a <= 1'b0;
      en_b <= 1'b1;
      frame(RD, 16, 4, resp(1'b0, 1'b1, 3'h7, 4'hf));
      en_b <= 1'b0;
      pulse(SD | LR | OC | C1V | C2G);
      frame(WR, 16, 4, resp(1'b0, 1'b0, 3'h0, 4'h9));
      frame(WR, 16, 4, resp(1'b0, 1'b0, 3'h0, 4'h9));
      frame(RD, 16, 4, resp(1'b0, 1'b0, 3'h0, 4'h9));
      frame(RD, 16, 4, resp(1'b0, 1'b0, 3'h7, 4'hf));
      pulse(SHL | OPN);
      frame(RD, 15, 4, 16'h0000);
      frame(RD, 16, 4, resp(1'b1, 1'b0, 3'h7, 4'hc));
      frame(RD, 16, 9, resp(1'b0, 1'b0, 3'h7, 4'hf));
      pulse(OPN | SD);
      frame(RD, 16, 4, resp(1'b0, 1'b0, 3'h3, 4'h3));
      pulse(C1G | C2V | OC);
      frame(RD, 16, 4, resp(1'b0, 1'b0, 3'h6, 4'h6));
      pulse(C1V | C1G);
      frame(RD, 16, 4, resp(1'b0, 1'b0, 3'h7, 4'hd));
      flt <= UV;
      frame(RD, 16, 4, resp(1'b0, 1'b0, 3'h7, 4'h0));
      flt <= 10'h000;
      frame(RD, 16, 4, resp(1'b0, 1'b0, 3'h7, 4'hf));
      final_report();
   end

   // watchdog: all frames take well under a third of this span
   initial begin
      #80000;
      n_mismatch++;
      $display("Error at %0t: watchdog expired", $time);
      final_report();
   end
endmodule : tb

// ===== verilog/drc_diag_readout.sv
/*
 * serial diagnostic readout: frame receive, response shift-out, fault latches.
 * assumes serial pins and fault levels are synchronous to i_clk and that the
 * serial clock is slow against i_clk (at least two i_clk periods per phase).
 */
`timescale 1ns/1ns
module drc_diag_readout (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe,
   input wire logic i_output_enable_cfg_a,
   input wire logic i_output_enable_cfg_b,
   input wire logic i_ch1_short_vs,
   input wire logic i_ch1_short_gnd,
   input wire logic i_ch2_short_vs,
   input wire logic i_ch2_short_gnd,
   input wire logic i_shorted_load,
   input wire logic i_open_load,
   input wire logic i_supply_undervoltage,
   input wire logic i_low_side_overcurrent,
   input wire logic i_limit_reduction_temp,
   input wire logic i_shutdown_temp
);
   drc_pkg::drc_state_e state_reg;
   drc_pkg::drc_latch_s latch_reg;
   drc_pkg::drc_latch_s latch_next;
   drc_pkg::drc_latch_s snap_reg;
   drc_pkg::drc_latch_s event_vec;
   drc_pkg::drc_latch_s clear_vec;
   logic cs_n_d_reg;
   logic sclk_d_reg;
   logic [15:0] rx_reg;
   logic [15:0] tx_reg;
   logic [4:0] rx_cnt_reg;
   logic [4:0] tx_cnt_reg;
   logic frame_start;
   logic frame_end;
   logic sclk_rise;
   logic sclk_fall;
   logic frame_valid;
   logic read_cmd;
   logic clear_now;
   logic en_live;

   ////////////////////////////////////////////////////////////////////////
   // four load diagnosis bits, highest priority first
   function automatic logic [3:0] encode_diag(input drc_pkg::drc_latch_s l,
                                              input logic uv);
      logic [1:0] p2;
      logic [1:0] p1;
      p2 = l.ch2_short_vs ? drc_pkg::PAIR_SHORT_VS :
           l.ch2_short_gnd ? drc_pkg::PAIR_SHORT_GND : drc_pkg::PAIR_NORMAL;
      p1 = l.ch1_short_vs ? drc_pkg::PAIR_SHORT_VS :
           l.ch1_short_gnd ? drc_pkg::PAIR_SHORT_GND : drc_pkg::PAIR_NORMAL;
      if (l.por || uv) begin
         encode_diag = drc_pkg::DIAG_SUPPLY;
      end else if (l.shorted_load) begin
         encode_diag = drc_pkg::DIAG_SHORTED;
      end else if (l.open_load) begin
         encode_diag = drc_pkg::DIAG_OPEN;
      end else begin
         encode_diag = {p2, p1};
      end
   endfunction : encode_diag

   // full response word from current latches and live levels
   function automatic logic [15:0] build_resp(input drc_pkg::drc_latch_s l,
                                              input logic uv, input logic en);
      logic [15:0] w;
      w = 16'h0000;
      w[drc_pkg::POS_VERIFY_LSB +: 5] = drc_pkg::VERIFY_PATTERN;
      w[drc_pkg::POS_FRAME_ERR] = l.frame_err;
      w[drc_pkg::POS_EN_LIVE] = en;
      w[drc_pkg::POS_OVERTEMP] = ~l.shutdown_temp;
      w[drc_pkg::POS_LIMIT_RED] = ~l.limit_temp;
      w[drc_pkg::POS_OVERCURRENT] = ~l.overcurrent;
      w[3:0] = encode_diag(l, uv);
      build_resp = w;
   endfunction : build_resp

   ////////////////////////////////////////////////////////////////////////
   // pin edge detection and frame decode
   assign frame_start = cs_n_d_reg && !i_cs_n;
   assign frame_end = (state_reg == drc_pkg::DRC_FRAME) && i_cs_n;
   assign sclk_rise = (state_reg == drc_pkg::DRC_FRAME) && i_sclk && !sclk_d_reg;
   assign sclk_fall = (state_reg == drc_pkg::DRC_FRAME) && !i_sclk && sclk_d_reg;
   assign frame_valid = (rx_cnt_reg == drc_pkg::FRAME_BITS_CNT);
   assign read_cmd = (rx_reg[15:8] == drc_pkg::CMD_DIAG_READ_CLEAR);
   assign clear_now = frame_end && frame_valid && read_cmd;
   assign en_live = i_output_enable_cfg_a | i_output_enable_cfg_b;

   // undriven during the two leading bits and outside frames
   assign o_miso_oe = (state_reg == drc_pkg::DRC_FRAME) &&
                      (tx_cnt_reg >= drc_pkg::HIZ_BITS) &&
                      (tx_cnt_reg < drc_pkg::FRAME_BITS_CNT);
   assign o_miso = tx_reg[15];

   // delayed copies of the pins for edge detection
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cs_n_d_reg <= 1'b1;
         sclk_d_reg <= 1'b0;
      end else begin
         cs_n_d_reg <= i_cs_n;
         sclk_d_reg <= i_sclk;
      end
   end

   // frame state
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= drc_pkg::DRC_IDLE;
      end else begin
         case (state_reg)
            drc_pkg::DRC_IDLE: begin
               if (frame_start) begin
                  state_reg <= drc_pkg::DRC_FRAME;
               end
            end
            drc_pkg::DRC_FRAME: begin
               if (i_cs_n) begin
                  state_reg <= drc_pkg::DRC_IDLE;
               end
            end
            default: begin
               state_reg <= drc_pkg::DRC_IDLE;
            end
         endcase
      end
   end

   // receive shifter, sampled on serial clock rise, count saturates
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_reg <= 16'h0000;
         rx_cnt_reg <= 5'h00;
      end else if (frame_start) begin
         rx_cnt_reg <= 5'h00;
      end else if (sclk_rise) begin
         rx_reg <= {rx_reg[14:0], i_mosi};
         if (rx_cnt_reg != 5'h1f) begin
            rx_cnt_reg <= rx_cnt_reg + 5'h01;
         end
      end
   end

   // response shifter, loaded at frame start, advanced on clock fall
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_reg <= 16'h0000;
         tx_cnt_reg <= 5'h00;
         snap_reg <= '0;
      end else if (frame_start) begin
         tx_reg <= build_resp(latch_reg, i_supply_undervoltage, en_live);
         tx_cnt_reg <= 5'h00;
         snap_reg <= latch_reg;
      end else if (sclk_fall) begin
         tx_reg <= {tx_reg[14:0], 1'b0};
         if (tx_cnt_reg != 5'h1f) begin
            tx_cnt_reg <= tx_cnt_reg + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fault events; set wins over clear, only bits latched at frame start are cleared
   always_comb begin
      event_vec = '0;
      event_vec.shorted_load = i_shorted_load;
      event_vec.open_load = i_open_load;
      event_vec.ch2_short_vs = i_ch2_short_vs;
      event_vec.ch2_short_gnd = i_ch2_short_gnd;
      event_vec.ch1_short_vs = i_ch1_short_vs;
      event_vec.ch1_short_gnd = i_ch1_short_gnd;
      event_vec.overcurrent = i_low_side_overcurrent;
      event_vec.limit_temp = i_limit_reduction_temp;
      event_vec.shutdown_temp = i_shutdown_temp;
      event_vec.frame_err = frame_end && !frame_valid;
      clear_vec = clear_now ? snap_reg : drc_pkg::drc_latch_s'('0);
      latch_next = (latch_reg & ~clear_vec) | event_vec;
   end

   // latch storage; power-on reset indication set by reset itself
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         latch_reg <= drc_pkg::LATCH_RESET;
      end else begin
         latch_reg <= latch_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_no_clear_invalid;
      @(posedge i_clk) disable iff (!i_rst_n)
      (frame_end && !frame_valid) |=>
         ((latch_reg & $past(latch_reg)) == $past(latch_reg));
   endproperty
   a_no_clear_invalid: assert property (p_no_clear_invalid)
      else $error("invalid frame cleared latched data");

   property p_no_clear_other;
      @(posedge i_clk) disable iff (!i_rst_n)
      (frame_end && frame_valid && !read_cmd) |=>
         ((latch_reg & $past(latch_reg)) == $past(latch_reg));
   endproperty
   a_no_clear_other: assert property (p_no_clear_other)
      else $error("non-read frame cleared latched data");

   property p_read_clears;
      @(posedge i_clk) disable iff (!i_rst_n)
      (clear_now && event_vec == '0) |=> ((latch_reg & $past(snap_reg)) == '0);
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("read command left reported bits set");

   property p_hiz_lead;
      @(posedge i_clk) disable iff (!i_rst_n)
      frame_start |=> !o_miso_oe;
   endproperty
   a_hiz_lead: assert property (p_hiz_lead)
      else $error("output driven in leading bits");

   property p_pattern;
      @(posedge i_clk) disable iff (!i_rst_n)
      frame_start |=> (tx_reg[drc_pkg::POS_VERIFY_LSB +: 5] == drc_pkg::VERIFY_PATTERN) &&
         (tx_reg[drc_pkg::POS_EN_LIVE] == $past(en_live));
   endproperty
   a_pattern: assert property (p_pattern)
      else $error("verification pattern or enable bit wrong");

   property p_supply_code;
      @(posedge i_clk) disable iff (!i_rst_n)
      (frame_start && latch_reg.por) |=> (tx_reg[3:0] == drc_pkg::DIAG_SUPPLY);
   endproperty
   a_supply_code: assert property (p_supply_code)
      else $error("power-on reset not reported as 0000");

   property p_oc_flag;
      @(posedge i_clk) disable iff (!i_rst_n)
      (frame_start && latch_reg.overcurrent) |=> !tx_reg[drc_pkg::POS_OVERCURRENT];
   endproperty
   a_oc_flag: assert property (p_oc_flag)
      else $error("overcurrent not reported low");

   // overcurrent event is latched on the next edge, whatever else happens
   property p_oc_latch;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_low_side_overcurrent |=> latch_reg.overcurrent;
   endproperty
   a_oc_latch: assert property (p_oc_latch)
      else $error("overcurrent event not latched");

   property p_frame_err;
      @(posedge i_clk) disable iff (!i_rst_n)
      (frame_end && !frame_valid) |=> latch_reg.frame_err [*2];
   endproperty
   a_frame_err: assert property (p_frame_err)
      else $error("frame error not latched");

   property p_hold;
      @(posedge i_clk) disable iff (!i_rst_n)
      (latch_reg.shutdown_temp && !clear_now) |=> latch_reg.shutdown_temp;
   endproperty
   a_hold: assert property (p_hold)
      else $error("latched fault dropped without read");

   c_read: cover property (@(posedge i_clk) disable iff (!i_rst_n) clear_now);
   c_invalid: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      frame_end && !frame_valid);
   c_other: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      frame_end && frame_valid && !read_cmd);
endmodule : drc_diag_readout

// ===== verilog/drc_pkg.sv
/*
 * constants, field layout and carrier types of the diagnostic readout block.
 * assumes a 16-bit serial frame, msb first, and one 250 MHz system clock.
 */
// Overview of operation
// - read command returns status then clears latches
// - only a valid read frame clears latches
// - configuration write returns status without clearing
// - top two bits undriven, then 10101
// - bits 8..0 carry error, enable, flags, diagnosis
// - load bits priority encoded, supply/shorted/open
// - channel pair 01 vs, 10 gnd, 11 normal
// - code 0000 for power-on reset or undervoltage
// - overcurrent flag low and latched on excess
// - limit reduction flag low and latched on heat
// - overtemperature flag low and latched on shutdown
// - enable bit live, OR of both enable bits
// - frame error flag set and latched
// - frame error reads 0 after valid read frame
package drc_pkg;
   localparam int FRAME_BITS = 16;
   localparam logic [4:0] FRAME_BITS_CNT = 5'h10;
   localparam logic [7:0] CMD_DIAG_READ_CLEAR = 8'h09;
   localparam logic [4:0] VERIFY_PATTERN = 5'h15;
   localparam int POS_VERIFY_LSB = 9;
   localparam int POS_FRAME_ERR = 8;
   localparam int POS_EN_LIVE = 7;
   localparam int POS_OVERTEMP = 6;
   localparam int POS_LIMIT_RED = 5;
   localparam int POS_OVERCURRENT = 4;
   localparam logic [4:0] HIZ_BITS = 5'h02;
   localparam logic [3:0] DIAG_SUPPLY = 4'h0;
   localparam logic [3:0] DIAG_SHORTED = 4'hc;
   localparam logic [3:0] DIAG_OPEN = 4'h3;
   localparam logic [1:0] PAIR_SHORT_VS = 2'h1;
   localparam logic [1:0] PAIR_SHORT_GND = 2'h2;
   localparam logic [1:0] PAIR_NORMAL = 2'h3;

   // latched fault set, also used as snapshot and event vector
   typedef struct packed {
      logic por;
      logic shorted_load;
      logic open_load;
      logic ch2_short_vs;
      logic ch2_short_gnd;
      logic ch1_short_vs;
      logic ch1_short_gnd;
      logic overcurrent;
      logic limit_temp;
      logic shutdown_temp;
      logic frame_err;
   } drc_latch_s;

   localparam drc_latch_s LATCH_RESET = '{por: 1'b1, default: 1'b0};

   typedef enum logic {DRC_IDLE, DRC_FRAME} drc_state_e;
endpackage : drc_pkg
